/* verilog/cpd_decoder.sv */
// configuration packet decoder: holds odometer, alignment, offsets and output rates
// What this block does
// RL1: odometer packet 192, 8 bytes, stores settings
// RL2: host sends alignment 193, length 5, key
// RL3: alignment only on exact key and length
// RL4: offsets packet 194, twelve floats from byte 1
// RL5: all offsets reset to zero
// RL6: primary offset drives every output
// RL7: heave offsets only for heave points 2-4
// RL8: output packet 195, fix selector, fifteen rates
// RL9: fix selector one forces 3D fix report while filter_init is high
// RL10: rate word: gpio low nibble, aux next
// RL11: index 1..9 maps 0.1 to 50 Hz
// RL12: indices 10-15 disabled; enabled sentences tick
`timescale 1ns/1ps
`default_nettype none
module cpd_decoder (
    input wire logic clk,
    input wire logic rst_n,
    // packet payload: header pulse with payload bytes held stable alongside
    input wire cpd_pkg::cpd_hdr_t pkt_hdr,
    input wire logic [8*cpd_pkg::MAX_LEN-1:0] pkt_data,
    // navigation filter state
    input wire logic filter_init,
    input wire logic raw_fix_3d,
    // odometer settings
    output cpd_pkg::cpd_odo_t odo_cfg,
    output logic odo_persist,
    // alignment
    output logic align_pulse,
    output logic align_persist,
    // offsets
    output logic [31:0] primary_ofs [3],
    output logic [31:0] heave_ofs [3][3],
    output logic ofs_persist,
    // nmea output configuration
    output logic fix_mode,
    output logic report_fix_3d,
    output logic out_persist,
    output logic [cpd_pkg::NUM_SENT-1:0] gpio_tick,
    output logic [cpd_pkg::NUM_SENT-1:0] aux_tick,
    output logic [cpd_pkg::NUM_SENT-1:0] gpio_en,
    output logic [cpd_pkg::NUM_SENT-1:0] aux_en
);
    // ****************************************
    // byte access and packet match
    // ****************************************
    function automatic logic [31:0] word_at(input logic [8*cpd_pkg::MAX_LEN-1:0] d, input int pos);
        word_at = d[8*pos +: 32];
    endfunction

    // only id, length and the alignment key gate a packet; reserved bytes are ignored
    logic hit_odo, hit_align, hit_ofs, hit_out;
    assign hit_odo = pkt_hdr.valid && pkt_hdr.id == cpd_pkg::ID_ODO && pkt_hdr.len == cpd_pkg::LEN_ODO; // RL1
    assign hit_align = pkt_hdr.valid && pkt_hdr.id == cpd_pkg::ID_ALIGN && pkt_hdr.len == cpd_pkg::LEN_ALIGN
        && word_at(pkt_data, 1) == cpd_pkg::ALIGN_KEY; // RL3
    assign hit_ofs = pkt_hdr.valid && pkt_hdr.id == cpd_pkg::ID_REFOFS && pkt_hdr.len == cpd_pkg::LEN_REFOFS; // RL4
    assign hit_out = pkt_hdr.valid && pkt_hdr.id == cpd_pkg::ID_OUTCFG && pkt_hdr.len == cpd_pkg::LEN_OUTCFG; // RL8

    // ****************************************
    // odometer settings
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            odo_cfg <= '0;
            odo_persist <= 1'b0;
        end else if (hit_odo) begin
            odo_persist <= pkt_data[0]; // RL1
            odo_cfg.persist <= pkt_data[0];
            odo_cfg.auto_meas <= pkt_data[8];
            odo_cfg.pulse_len <= word_at(pkt_data, cpd_pkg::ODO_PULSE_POS);
        end
    end

    // ****************************************
    // zero orientation alignment
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            align_pulse <= 1'b0;
        end else begin
            align_pulse <= hit_align; // RL3
        end
    end

    // a refused packet leaves the last accepted persist flag in place
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            align_persist <= 1'b0;
        end else if (hit_align) begin
            align_persist <= pkt_data[0]; // RL3
        end
    end

    // ****************************************
    // reference point offsets
    // ****************************************
    // offsets are only held here; the output paths downstream add the primary set
    // to every output and the heave sets to heave points 2-4 alone
    genvar g;
    generate
        for (g = 0; g < cpd_pkg::NUM_OFS; g++) begin : g_ofs
            logic [31:0] ofs_r;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ofs_r <= cpd_pkg::OFS_RST; // RL5
                end else if (hit_ofs) begin
                    ofs_r <= word_at(pkt_data, cpd_pkg::OFS_POS + 4 * g); // RL4
                end
            end
            if (g < 3) begin : g_pri
                assign primary_ofs[g] = ofs_r; // RL6
            end else begin : g_hv
                assign heave_ofs[(g - 3) / 3][(g - 3) % 3] = ofs_r; // RL7
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ofs_persist <= 1'b0;
        end else if (hit_ofs) begin
            ofs_persist <= pkt_data[0];
        end
    end

    // ****************************************
    // output configuration and fix behaviour
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fix_mode <= 1'b0;
        end else if (hit_out) begin
            fix_mode <= pkt_data[8*cpd_pkg::FIX_POS +: 8] == 8'h01; // RL9
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_persist <= 1'b0;
        end else if (hit_out) begin
            out_persist <= pkt_data[0]; // RL8
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            report_fix_3d <= 1'b0;
        end else begin
            // any selector other than 1 leaves the raw fix indication as it is
            report_fix_3d <= (fix_mode && filter_init) || raw_fix_3d; // RL9
        end
    end

    // ****************************************
    // per-sentence rate timers
    // ****************************************
    // periods are counted in cycles of the 250 MHz clock; another clock scales every rate
    function automatic logic [31:0] period_of(input logic [3:0] idx);
        if (idx == 4'h0 || idx > 4'h9) begin
            period_of = 32'h00000000; // RL12
        end else begin
            period_of = cpd_pkg::RATE_PER[idx - 4'h1]; // RL11
        end
    endfunction

    generate
        for (g = 0; g < 2 * cpd_pkg::NUM_SENT; g++) begin : g_rate
            logic [3:0] idx_in;
            logic [3:0] idx_r;
            logic [31:0] cnt_r;
            logic [31:0] per;
            logic wrap;
            logic tick_r;
            logic en_r;
            // even instances take the low nibble of a rate word, odd ones the next; the high byte is ignored
            assign idx_in = pkt_data[8*(cpd_pkg::RATE_POS + 2 * (g / 2)) + 4 * (g % 2) +: 4]; // RL10
            assign per = period_of(idx_r);
            assign wrap = cnt_r >= per - 32'h00000001;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    idx_r <= cpd_pkg::RATE_RST[3:0];
                end else if (hit_out) begin
                    idx_r <= idx_in; // RL10
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    en_r <= 1'b0;
                end else if (hit_out) begin
                    en_r <= period_of(idx_in) != 32'h00000000; // RL12
                end
            end
            // a new output packet restarts every timer, so a changed rate never inherits a part-run count
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_r <= '0;
                end else if (per == 32'h00000000 || hit_out) begin
                    cnt_r <= '0;
                end else if (wrap) begin
                    cnt_r <= '0;
                end else begin
                    cnt_r <= cnt_r + 32'h00000001;
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    tick_r <= 1'b0;
                end else if (per == 32'h00000000 || hit_out) begin
                    tick_r <= 1'b0;
                end else begin
                    tick_r <= wrap; // RL12
                end
            end
            if (g % 2 == 0) begin : g_gpio
                assign gpio_tick[g / 2] = tick_r;
                assign gpio_en[g / 2] = en_r;
            end else begin : g_aux
                assign aux_tick[g / 2] = tick_r;
                assign aux_en[g / 2] = en_r;
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* verilog/cpd_pkg.sv */
// package of constants and types for the configuration packet decoder
`default_nettype none
package cpd_pkg;
    // ****************************************
    // packet identifiers and lengths
    // ****************************************
    localparam logic [7:0] ID_ODO = 8'hC0;
    localparam logic [7:0] ID_ALIGN = 8'hC1;
    localparam logic [7:0] ID_REFOFS = 8'hC2;
    localparam logic [7:0] ID_OUTCFG = 8'hC3;
    localparam logic [5:0] LEN_ODO = 6'h08;
    localparam logic [5:0] LEN_ALIGN = 6'h05;
    localparam logic [5:0] LEN_REFOFS = 6'h31;
    localparam logic [5:0] LEN_OUTCFG = 6'h21;
    localparam logic [31:0] ALIGN_KEY = 32'h9A4E8055;
    localparam int MAX_LEN = 49;
    localparam int NUM_OFS = 12;
    localparam int NUM_SENT = 15;
    localparam int NUM_RATE = 9;
    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int ODO_PULSE_POS = 4;
    localparam int OFS_POS = 1;
    localparam int RATE_POS = 2;
    localparam int FIX_POS = 1;
    localparam logic [31:0] OFS_RST = 32'h00000000;
    localparam logic [15:0] RATE_RST = 16'h0000;
    // rate period in clock cycles at 250 MHz, index 1..9 = 0.1 .. 50 Hz
    localparam longint CLK_HZ = 250000000;
    localparam logic [31:0] RATE_PER [NUM_RATE] = '{
        32'(CLK_HZ * 10), 32'(CLK_HZ * 5), 32'(CLK_HZ * 2), 32'(CLK_HZ), 32'(CLK_HZ / 2),
        32'(CLK_HZ / 5), 32'(CLK_HZ / 10), 32'(CLK_HZ / 25), 32'(CLK_HZ / 50)};

    typedef struct packed {
        logic valid;
        logic [7:0] id;
        logic [5:0] len;
    } cpd_hdr_t;

    typedef struct packed {
        logic persist;
        logic auto_meas;
        logic [31:0] pulse_len;
    } cpd_odo_t;
endpackage
`default_nettype wire

/* tb/cpd_host_model.sv */
// host model that sends configuration packets to the decoder
`timescale 1ns/1ps
`default_nettype none
module cpd_host_model (
    // clock
    input wire logic clk,
    // packet out
    output cpd_pkg::cpd_hdr_t pkt_hdr,
    output logic [8*cpd_pkg::MAX_LEN-1:0] pkt_data
);
    initial begin
        pkt_hdr = '0;
        pkt_data = '0;
    end
    // one-cycle header pulse; released payload is inverted so stale bytes never look valid
    task automatic send(input logic [7:0] id, input logic [5:0] len, input logic [391:0] d);
        @(negedge clk);
        pkt_hdr = {1'b1, id, len};
        pkt_data = d;
        @(negedge clk);
        pkt_hdr.valid = 1'b0;
        pkt_data = ~d;
    endtask
endmodule
`default_nettype wire

/* tb/cpd_decoder_monitor.sv */
// assertion checker for the configuration packet decoder
`timescale 1ns/1ps
`default_nettype none
module cpd_decoder_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // packet side
    input wire cpd_pkg::cpd_hdr_t pkt_hdr,
    input wire logic [8*cpd_pkg::MAX_LEN-1:0] pkt_data,
    input wire logic filter_init,
    input wire logic raw_fix_3d,
    // decoded settings
    input wire cpd_pkg::cpd_odo_t odo_cfg,
    input wire logic align_pulse,
    input wire logic fix_mode,
    input wire logic report_fix_3d,
    input wire logic [cpd_pkg::NUM_SENT-1:0] gpio_tick,
    input wire logic [cpd_pkg::NUM_SENT-1:0] aux_tick,
    input wire logic [cpd_pkg::NUM_SENT-1:0] gpio_en,
    input wire logic [cpd_pkg::NUM_SENT-1:0] aux_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic key_ok;
    logic oc;
    assign key_ok = pkt_hdr == {1'b1, cpd_pkg::ID_ALIGN, cpd_pkg::LEN_ALIGN} && pkt_data[39:8] == cpd_pkg::ALIGN_KEY;
    assign oc = pkt_hdr == {1'b1, cpd_pkg::ID_OUTCFG, cpd_pkg::LEN_OUTCFG};
    sequence s_odo;
        pkt_hdr == {1'b1, cpd_pkg::ID_ODO, cpd_pkg::LEN_ODO};
    endsequence
    sequence s_key;
        key_ok;
    endsequence
    a_align_fire: assert property (s_key |=> align_pulse)
        else $error("alignment not commanded");
    a_align_cause: assert property (align_pulse |-> $past(key_ok))
        else $error("alignment without key");
    a_odo_store: assert property (s_odo |=> odo_cfg.pulse_len == $past(pkt_data[63:32])
        && odo_cfg.auto_meas == $past(pkt_data[8])) else $error("odometer settings wrong");
    a_fix_mode: assert property (oc |=> fix_mode == ($past(pkt_data[15:8]) == 8'h01))
        else $error("fix mode wrong");
    a_fix_hold: assert property (!oc |=> $stable(fix_mode))
        else $error("fix mode changed");
    a_fix_report: assert property (report_fix_3d == $past(fix_mode && filter_init || raw_fix_3d))
        else $error("fix report wrong");
    a_gpio_idx: assert property (oc |=> gpio_en[0] == ($past(pkt_data[19:16]) inside {[1:9]}))
        else $error("gpio enable wrong");
    a_aux_idx: assert property (oc |=> aux_en[14] == ($past(pkt_data[247:244]) inside {[1:9]}))
        else $error("aux enable wrong");
    a_tick_off: assert property (((gpio_tick & ~gpio_en) | (aux_tick & ~aux_en)) == '0)
        else $error("tick on disabled output");
endmodule
bind cpd_decoder cpd_decoder_monitor u_mon (.clk(clk), .rst_n(rst_n), .pkt_hdr(pkt_hdr), .pkt_data(pkt_data),
    .filter_init(filter_init), .raw_fix_3d(raw_fix_3d), .odo_cfg(odo_cfg), .align_pulse(align_pulse),
    .fix_mode(fix_mode), .report_fix_3d(report_fix_3d), .gpio_tick(gpio_tick), .aux_tick(aux_tick),
    .gpio_en(gpio_en), .aux_en(aux_en));
`default_nettype wire

/* tb/test_config_packet_decoder.sv */
// self-checking bench for the configuration packet decoder
`timescale 1ns/1ps
`default_nettype none
module test_config_packet_decoder;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic filter_init = 1'b0;
    logic raw_fix_3d = 1'b0;
    cpd_pkg::cpd_hdr_t pkt_hdr;
    cpd_pkg::cpd_odo_t odo_cfg;
    logic [391:0] pkt_data, d;
    logic odo_persist, align_pulse, align_persist, ofs_persist, fix_mode, report_fix_3d, out_persist;
    logic [31:0] primary_ofs [3];
    logic [31:0] heave_ofs [3][3];
    logic [14:0] gpio_tick, aux_tick, gpio_en, aux_en;
    int fails = 0;
    int samples_checked = 0;
    always #2 clk = ~clk;
    cpd_host_model host (.clk(clk), .pkt_hdr(pkt_hdr), .pkt_data(pkt_data));
    cpd_decoder dut (.clk(clk), .rst_n(rst_n), .pkt_hdr(pkt_hdr), .pkt_data(pkt_data), .filter_init(filter_init),
        .raw_fix_3d(raw_fix_3d), .odo_cfg(odo_cfg), .odo_persist(odo_persist), .align_pulse(align_pulse),
        .align_persist(align_persist), .primary_ofs(primary_ofs), .heave_ofs(heave_ofs), .ofs_persist(ofs_persist),
        .fix_mode(fix_mode), .report_fix_3d(report_fix_3d), .out_persist(out_persist), .gpio_tick(gpio_tick),
        .aux_tick(aux_tick), .gpio_en(gpio_en), .aux_en(aux_en));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("fails %0d checks %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic t_odo;
        d = '0;
        d[15:0] = 16'h0101;
        d[63:32] = 32'h3F000000;
        host.send(cpd_pkg::ID_ODO, cpd_pkg::LEN_ODO, d);
        chk({odo_cfg.pulse_len}, 32'h3F000000);
        chk({odo_cfg.persist, odo_cfg.auto_meas, odo_persist}, 32'h7);
        host.send(cpd_pkg::ID_ODO, 6'h07, ~d);
        chk(odo_cfg.pulse_len, 32'h3F000000);
        $display("odometer test done");
    endtask
    task automatic t_align;
        d = '0;
        d[7:0] = 8'h01;
        d[39:8] = cpd_pkg::ALIGN_KEY ^ 32'h1;
        host.send(cpd_pkg::ID_ALIGN, cpd_pkg::LEN_ALIGN, d);
        chk({align_pulse, align_persist}, 32'h0);
        d[39:8] = cpd_pkg::ALIGN_KEY;
        host.send(cpd_pkg::ID_ALIGN, 6'h06, d);
        chk({align_pulse, align_persist}, 32'h0);
        host.send(cpd_pkg::ID_ALIGN, cpd_pkg::LEN_ALIGN, d);
        chk({align_pulse, align_persist}, 32'h3);
        @(negedge clk);
        chk(align_pulse, 32'h0);
        d[7:0] = 8'h00;
        d[39:8] = ~cpd_pkg::ALIGN_KEY;
        host.send(cpd_pkg::ID_ALIGN, cpd_pkg::LEN_ALIGN, d);
        chk({align_pulse, align_persist}, 32'h1);
        $display("alignment test done");
    endtask
    task automatic t_ofs;
        foreach (primary_ofs[i]) chk(primary_ofs[i], 32'h0);
        foreach (heave_ofs[p, a]) chk(heave_ofs[p][a], 32'h0);
        d = '0;
        d[7:0] = 8'h01;
        for (int i = 0; i < 12; i++) d[8 + 32 * i +: 32] = 32'h40000000 + 32'(i);
        host.send(cpd_pkg::ID_REFOFS, cpd_pkg::LEN_REFOFS, d);
        foreach (primary_ofs[i]) chk(primary_ofs[i], 32'h40000000 + 32'(i));
        foreach (heave_ofs[p, a]) chk(heave_ofs[p][a], 32'h40000003 + 32'(3 * p + a));
        chk(ofs_persist, 32'h1);
        $display("offset test done");
    endtask
    task automatic t_out;
        d = '0;
        d[7:0] = 8'h01;
        d[15:8] = 8'h01;
        for (int n = 0; n < 15; n++) d[16 + 16 * n +: 16] = {8'h00, 4'(15 - n), 4'(n)};
        filter_init = 1'b1;
        host.send(cpd_pkg::ID_OUTCFG, cpd_pkg::LEN_OUTCFG, d);
        chk(fix_mode, 32'h1);
        chk(out_persist, 32'h1);
        for (int n = 0; n < 15; n++) chk({gpio_en[n], aux_en[n]}, {30'h0, n >= 1 && n <= 9, n >= 6});
        @(negedge clk);
        chk(report_fix_3d, 32'h1);
        filter_init = 1'b0;
        @(negedge clk);
        chk(report_fix_3d, 32'h0);
        filter_init = 1'b1;
        repeat (1000) begin
            @(negedge clk);
            chk({2'h0, gpio_tick, aux_tick}, 32'h0);
        end
        d[15:8] = 8'h00;
        host.send(cpd_pkg::ID_OUTCFG, cpd_pkg::LEN_OUTCFG, d);
        @(negedge clk);
        chk(report_fix_3d, 32'h0);
        raw_fix_3d = 1'b1;
        @(negedge clk);
        chk(report_fix_3d, 32'h1);
        $display("output config test done");
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        t_odo;
        t_align;
        t_ofs;
        t_out;
        stop_test;
    end
    // tests take about four microseconds
    initial begin
        #40000;
        fails++;
        stop_test;
    end
endmodule
`default_nettype wire
